// ===== common/smbus_nv_consts.vh
`ifndef SMBUS_NV_CONSTS_VH
`define SMBUS_NV_CONSTS_VH
`define DEV_ADDR_HI      4'h9
`define CMD_COPY_V2NV    8'h48
`define ARA_BYTE         8'h19
`define GC_BYTE          8'h00
`define GC_RELATCH       8'h04
`define GC_RESET         8'h06
`define CLK_PERIOD_PS    5000
`define NV_PROGRAM_TIME_US   20
`define RESET_RELOAD_TIME_US 1
`define TIMEOUT_MIN_US   25
`define TIMEOUT_MAX_US   35
`define NV_PROGRAM_CYC   ((`NV_PROGRAM_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define RESET_RELOAD_CYC ((`RESET_RELOAD_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define TIMEOUT_CYC      ((`TIMEOUT_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CFG_W            16
`define LIM_W            16
`endif

// ===== logic/pin_sync.v
`timescale 1ns/1ps
module pin_sync (
	input  wire core_clk_i,
	input  wire reset_n_i,
	input  wire enable_i,
	input  wire pin_i,
	output wire sync_o
);
	reg meta_q;
	reg sync_q;
	// reset high: bus idle level
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else if (enable_i) begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule

// ===== logic/busy_timer.v
`timescale 1ns/1ps
module busy_timer #(
	parameter [23:0] COPY_CYC   = 24'h000FA0,
	parameter [23:0] RELOAD_CYC = 24'h0000C8
) (
	input  wire core_clk_i,
	input  wire reset_n_i,
	input  wire enable_i,
	input  wire start_copy_i,
	input  wire start_reload_i,
	output wire busy_o,
	output reg  done_copy_o,
	output reg  done_reload_o
);
	reg [23:0] count_q;
	reg        kind_q;
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_q       <= 24'h000000;
			kind_q        <= 1'b0;
			done_copy_o   <= 1'b0;
			done_reload_o <= 1'b0;
		end else if (enable_i) begin
			done_copy_o   <= 1'b0;
			done_reload_o <= 1'b0;
			if (count_q == 24'h000000) begin
				if (start_reload_i) begin
					count_q <= RELOAD_CYC;
					kind_q  <= 1'b1;
				end else if (start_copy_i) begin
					count_q <= COPY_CYC;
					kind_q  <= 1'b0;
				end
			end else begin
				count_q <= count_q - 24'h000001;
				if (count_q == 24'h000001) begin
					done_copy_o   <= ~kind_q;
					done_reload_o <= kind_q;
				end
			end
		end
	end
	assign busy_o = (count_q != 24'h000000);
endmodule

// ===== logic/smbus_nv_copy_alert_control.v
`timescale 1ns/1ps
`include "smbus_nv_consts.vh"
module smbus_nv_copy_alert_control #(
	parameter [23:0] NV_PROGRAM_CYC   = `NV_PROGRAM_CYC,
	parameter [23:0] RESET_RELOAD_CYC = `RESET_RELOAD_CYC,
	parameter [23:0] TIMEOUT_CYC      = `TIMEOUT_CYC
) (
	input  wire               core_clk_i,
	input  wire               reset_n_i,
	input  wire               clk_en_i,
	input  wire               scl_i,
	input  wire               sda_i,
	output wire               sda_o,
	output wire               sda_oe_n_o,
	input  wire [2:0]         addr_pins_i,
	output reg  [2:0]         addr_latched_o,
	input  wire [`CFG_W-1:0]  config_i,
	input  wire [`LIM_W-1:0]  low_limit_i,
	input  wire [`LIM_W-1:0]  high_limit_i,
	output reg  [`CFG_W-1:0]  nv_config_o,
	output reg  [`LIM_W-1:0]  nv_low_limit_o,
	output reg  [`LIM_W-1:0]  nv_high_limit_o,
	input  wire               lock_bit_i,
	input  wire               permanent_lockdown_bit_i,
	input  wire               thermostat_interrupt_select_i,
	input  wire               alert_polarity_i,
	input  wire               high_event_i,
	input  wire               low_event_i,
	output wire               alert_n_o,
	output wire               nv_busy_flag_o,
	output reg                reload_pulse_o,
	output reg                pointer_write_o,
	output reg  [7:0]         pointer_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX   = 3'h1;
	localparam [2:0] ST_ACK  = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_IGN  = 3'h4;
	localparam [2:0] PH_ADDR = 3'h0;
	localparam [2:0] PH_CMD  = 3'h1;
	localparam [2:0] PH_GC   = 3'h2;
	localparam [2:0] PH_ARA  = 3'h3;
	localparam [2:0] PH_DATA = 3'h4;

	wire scl_s;
	wire sda_s;
	pin_sync u_scl (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enable_i(clk_en_i), .pin_i(scl_i),
		.sync_o(scl_s));
	pin_sync u_sda (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enable_i(clk_en_i), .pin_i(sda_i),
		.sync_o(sda_s));

	// strapping pins are asynchronous too, so they get the same two stages
	wire [2:0] addr_s;
	genvar     gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_addr_sync
			pin_sync u_addr (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enable_i(clk_en_i),
				.pin_i(addr_pins_i[gi]), .sync_o(addr_s[gi]));
		end
	endgenerate

	reg        scl_q;
	reg        sda_q;
	reg [2:0]  state_q;
	reg [2:0]  phase_q;
	reg [7:0]  shift_q;
	reg [3:0]  bit_q;
	reg        ack_q;
	reg        drive_low_q;
	reg        copy_armed_q;
	reg        alert_q;
	reg        limit_q;
	reg [23:0] low_cnt_q;
	reg        start_copy_q;
	reg        start_reload_q;
	reg [1:0]  init_cnt_q;
	wire       busy;
	wire       done_copy;
	wire       done_reload;

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
	wire smbus_alert_en = thermostat_interrupt_select_i & ~alert_polarity_i;
	wire timeout  = (low_cnt_q >= TIMEOUT_CYC);

	busy_timer #(.COPY_CYC(NV_PROGRAM_CYC), .RELOAD_CYC(RESET_RELOAD_CYC)) u_timer (
		.core_clk_i     (core_clk_i),
		.reset_n_i      (reset_n_i),
		.enable_i       (clk_en_i),
		.start_copy_i   (start_copy_q),
		.start_reload_i (start_reload_q),
		.busy_o         (busy),
		.done_copy_o    (done_copy),
		.done_reload_o  (done_reload)
	);
	assign nv_busy_flag_o = busy;

	// decides acknowledge for a received byte and the next phase
	function [3:0] decode_byte;
		input [2:0] ph;
		input [7:0] b;
		input [2:0] a;
		input       bsy;
		input       alerting;
		begin
			decode_byte = {1'b0, PH_DATA};
			case (ph)
				PH_ADDR: begin
					if (b == {`DEV_ADDR_HI, a, 1'b0})
						decode_byte = {1'b1, PH_CMD};
					else if (b == {`DEV_ADDR_HI, a, 1'b1})
						decode_byte = {~bsy, PH_DATA};
					else if (b == `GC_BYTE)
						decode_byte = {~bsy, PH_GC};
					else if (b == `ARA_BYTE)
						decode_byte = {alerting & ~bsy, PH_ARA};
				end
				PH_CMD:  decode_byte = {1'b1, PH_DATA};
				PH_GC:   decode_byte = {(b == `GC_RELATCH) | (b == `GC_RESET), PH_DATA};
				default: decode_byte = {1'b0, PH_DATA};
			endcase
		end
	endfunction

	wire [3:0] dec = decode_byte(phase_q, shift_q, addr_latched_o, busy, alert_q & smbus_alert_en);
	// limit cause rides in the lsb of the reply
	wire [7:0] ara_reply = {`DEV_ADDR_HI, addr_latched_o, limit_q};

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_q           <= 1'b1;
			sda_q           <= 1'b1;
			state_q         <= ST_IDLE;
			phase_q         <= PH_ADDR;
			shift_q         <= 8'h00;
			bit_q           <= 4'h0;
			ack_q           <= 1'b0;
			drive_low_q     <= 1'b0;
			copy_armed_q    <= 1'b0;
			alert_q         <= 1'b0;
			limit_q         <= 1'b0;
			low_cnt_q       <= 24'h000000;
			start_copy_q    <= 1'b0;
			start_reload_q  <= 1'b0;
			init_cnt_q      <= 2'h0;
			addr_latched_o  <= 3'h0;
			reload_pulse_o  <= 1'b0;
			pointer_write_o <= 1'b0;
			pointer_o       <= 8'h00;
			nv_config_o     <= {`CFG_W{1'b0}};
			nv_low_limit_o  <= {`LIM_W{1'b0}};
			nv_high_limit_o <= {`LIM_W{1'b0}};
		end else if (clk_en_i) begin
			scl_q           <= scl_s;
			sda_q           <= sda_s;
			start_copy_q    <= 1'b0;
			start_reload_q  <= 1'b0;
			reload_pulse_o  <= done_reload;
			pointer_write_o <= 1'b0;
			// pins caught after reset release, once the synchroniser holds them
			if (init_cnt_q != 2'h3) begin
				init_cnt_q <= init_cnt_q + 2'h1;
				if (init_cnt_q == 2'h2)
					addr_latched_o <= addr_s;
			end
			if (done_copy) begin
				nv_config_o     <= config_i;
				nv_low_limit_o  <= low_limit_i;
				nv_high_limit_o <= high_limit_i;
			end
			// event wins over the ARA clear; high cause takes priority
			if (high_event_i | low_event_i) begin
				alert_q <= 1'b1;
				limit_q <= high_event_i;
			end
			low_cnt_q <= scl_s ? 24'h000000 : (timeout ? low_cnt_q : low_cnt_q + 24'h000001);
			if (timeout) begin
				// release immediately; any start after scl rises is accepted
				state_q      <= ST_IDLE;
				drive_low_q  <= 1'b0;
				copy_armed_q <= 1'b0;
			end else if (start_c) begin
				copy_armed_q <= 1'b0;
				state_q      <= ST_RX;
				phase_q      <= PH_ADDR;
				bit_q        <= 4'h0;
				drive_low_q  <= 1'b0;
			end else if (stop_c) begin
				if (copy_armed_q)
					start_copy_q <= 1'b1;
				copy_armed_q <= 1'b0;
				state_q      <= ST_IDLE;
				drive_low_q  <= 1'b0;
			end else begin
				case (state_q)
					ST_RX: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_s};
							bit_q   <= bit_q + 4'h1;
						end else if (scl_fall && bit_q == 4'h8) begin
							ack_q       <= dec[3];
							drive_low_q <= dec[3];
							state_q     <= ST_ACK;
							if (phase_q == PH_CMD) begin
								if (shift_q == `CMD_COPY_V2NV)
									copy_armed_q <= ~busy & ~lock_bit_i & ~permanent_lockdown_bit_i;
								else begin
									pointer_o       <= shift_q;
									pointer_write_o <= 1'b1;
								end
							end
							if (phase_q == PH_GC && dec[3]) begin
								addr_latched_o <= addr_s;
								if (shift_q == `GC_RESET)
									start_reload_q <= 1'b1;
							end
							phase_q <= dec[2:0];
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							bit_q <= 4'h0;
							if (!ack_q) begin
								drive_low_q <= 1'b0;
								state_q     <= ST_IGN;
							end else if (phase_q == PH_ARA) begin
								shift_q     <= ara_reply;
								drive_low_q <= ~ara_reply[7];
								state_q     <= ST_TX;
							end else begin
								drive_low_q <= 1'b0;
								state_q     <= (phase_q == PH_DATA) ? ST_IGN : ST_RX;
							end
						end
					end
					ST_TX: begin
						if (scl_rise && !drive_low_q && !sda_s) begin
							drive_low_q <= 1'b0;
							state_q     <= ST_IGN;
						end else if (scl_fall) begin
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h7) begin
								drive_low_q <= 1'b0;
								alert_q     <= high_event_i | low_event_i;
								state_q     <= ST_IGN;
							end else begin
								drive_low_q <= ~shift_q[3'h6 - bit_q[2:0]];
							end
						end
					end
					ST_IGN:  drive_low_q <= 1'b0;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// open drain: enable active low while pulling the line low
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~drive_low_q;
	assign alert_n_o  = ~(alert_q & smbus_alert_en);
endmodule

// ===== test/smbus_nv_chk.sv
`timescale 1ns/1ps
module smbus_nv_chk #(
	parameter [23:0] TIMEOUT_CYC = 24'h0000C8
) (
	input wire        core_clk_i,
	input wire        reset_n_i,
	input wire        scl_i,
	input wire        sda_i,
	input wire        sda_o,
	input wire        sda_oe_n_o,
	input wire [15:0] nv_config_o,
	input wire        thermostat_interrupt_select_i,
	input wire        alert_polarity_i,
	input wire        high_event_i,
	input wire        low_event_i,
	input wire        alert_n_o,
	input wire        nv_busy_flag_o,
	input wire        reload_pulse_o
);
	localparam int BUSY_MAX = 900;
	reg [11:0] low_q;
	// saturates so a stuck clock cannot wrap under the limit
	always @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			low_q <= 12'h000;
		else
			low_q <= scl_i ? 12'h000 : low_q + {11'h000, low_q != 12'hFFF};
	reg       sda_d_q;
	reg [3:0] since_stop_q;
	// cycles since the last stop seen on the raw pins, saturating
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_d_q      <= 1'b1;
			since_stop_q <= 4'hF;
		end else begin
			sda_d_q      <= sda_i;
			since_stop_q <= (scl_i && sda_i && !sda_d_q) ? 4'h0 : since_stop_q + {3'h0, since_stop_q != 4'hF};
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_timeout_release: assert property (low_q > TIMEOUT_CYC + 12 |-> sda_oe_n_o)
		else $error("sda held");
	a_drive_low: assert property (!sda_oe_n_o |-> !sda_o)
		else $error("sda driven high");
	a_busy_span: assert property ($rose(nv_busy_flag_o) |-> nv_busy_flag_o[*8] ##[1:BUSY_MAX] !nv_busy_flag_o)
		else $error("busy span");
	a_busy_on_stop: assert property ($rose(nv_busy_flag_o) && scl_i |-> since_stop_q < 4'h8)
		else $error("busy not after stop");
	a_nv_at_end: assert property (!$stable(nv_config_o) |-> !nv_busy_flag_o &&
		($past(nv_busy_flag_o) || $past(nv_busy_flag_o, 2))) else $error("nv update");
	a_alert_mode: assert property ($fell(alert_n_o) |->
		thermostat_interrupt_select_i && !alert_polarity_i) else $error("alert mode");
	a_alert_raise: assert property ((high_event_i || low_event_i) &&
		thermostat_interrupt_select_i && !alert_polarity_i |-> ##[1:4] !alert_n_o) else $error("alert late");
	a_reload_once: assert property (reload_pulse_o |=> !reload_pulse_o)
		else $error("reload pulse");
endmodule
bind smbus_nv_copy_alert_control smbus_nv_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.nv_config_o(nv_config_o), .thermostat_interrupt_select_i(thermostat_interrupt_select_i),
	.alert_polarity_i(alert_polarity_i), .high_event_i(high_event_i), .low_event_i(low_event_i),
	.alert_n_o(alert_n_o), .nv_busy_flag_o(nv_busy_flag_o), .reload_pulse_o(reload_pulse_o));

// ===== test/bus_master.sv
`timescale 1ns/1ps
module bus_master (
	output logic scl_o,
	output wire  sda_line_o,
	input  wire  dev_low_i
);
	logic sda_q = 1'b1;
	initial scl_o = 1'b1;
	// pull-up: line high unless a party pulls it low
	assign sda_line_o = sda_q & ~dev_low_i;
	// long low phase leaves room for the slave's synchroniser delay
	task automatic bit_io(input logic b, output logic r);
		#24 sda_q = b;
		#16 scl_o = 1'b1;
		#12 r = sda_line_o;
		#12 scl_o = 1'b0;
	endtask
	task automatic start();
		#24 sda_q = 1'b1;
		#16 scl_o = 1'b1;
		#16 sda_q = 1'b0;
		#16 scl_o = 1'b0;
	endtask
	task automatic stop();
		#24 sda_q = 1'b0;
		#16 scl_o = 1'b1;
		#16 sda_q = 1'b1;
		#32;
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd_byte(input logic [7:0] pull, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(pull[i], b[i]);
		bit_io(1'b1, r);
	endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "smbus_nv_consts.vh"
module testbench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  pins;
	logic [15:0] cfg = 16'h0000, lo = 16'h0000, hi = 16'h0000;
	logic        lk = 1'b0, lkd = 1'b0, tis = 1'b1, alert_polarity = 1'b0, hev = 1'b0, lev = 1'b0;
	logic        ack;
	logic [7:0]  rb;
	logic [47:0] exp_nv = 48'h0;
	int          errors = 0, total_checks = 0, cyc = 0, reloads = 0, ptr_w = 0;
	wire         scl, sda, sda_o, oe_n, alert_n, busy, reload, pw;
	wire [2:0]   addr_q;
	wire [15:0]  nv_c, nv_l, nv_h;
	wire [7:0]   ptr;
	always #2.5 clk = ~clk;
	initial pins = {1'b1, 2'($urandom(32'h7df874bc))};
	bus_master m (.scl_o(scl), .sda_line_o(sda), .dev_low_i(~oe_n & ~sda_o));
	smbus_nv_copy_alert_control #(.NV_PROGRAM_CYC(24'h000320), .RESET_RELOAD_CYC(24'h00000A),
		.TIMEOUT_CYC(24'h0000C8)) dut (.core_clk_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n), .addr_pins_i(pins),
		.addr_latched_o(addr_q), .config_i(cfg), .low_limit_i(lo), .high_limit_i(hi),
		.nv_config_o(nv_c), .nv_low_limit_o(nv_l), .nv_high_limit_o(nv_h), .lock_bit_i(lk),
		.permanent_lockdown_bit_i(lkd), .thermostat_interrupt_select_i(tis),
		.alert_polarity_i(alert_polarity), .high_event_i(hev), .low_event_i(lev), .alert_n_o(alert_n),
		.nv_busy_flag_o(busy), .reload_pulse_o(reload), .pointer_write_o(pw), .pointer_o(ptr));
	always @(posedge clk) begin
		cyc++;
		reloads += reload;
		ptr_w += pw;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] want);
		total_checks++;
		if (got !== want) begin
			errors++;
			$display("unexpected at %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [1:0] ex);
		m.start();
		m.wr_byte(a, ack);
		chk(ack, ex[1]);
		m.wr_byte(c, ack);
		chk(ack, ex[0]);
	endtask
	task automatic ev(input logic h);
		@(posedge clk) #1 {hev, lev} = {h, ~h};
		@(posedge clk) #1 {hev, lev} = 2'b00;
		repeat (6) @(posedge clk);
	endtask
	function automatic logic [7:0] reply(input logic [2:0] a, input logic h);
		reply = {`DEV_ADDR_HI, a, h};
	endfunction
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (10) @(posedge clk);
		ev(1'b1);
		chk(alert_n, 1'b0);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) #1 {cfg, lo, hi} = {16'($urandom), 16'($urandom), 16'($urandom)};
			{lk, lkd} = {k == 2, k == 3};
			xfer({`DEV_ADDR_HI, pins, 1'b0}, `CMD_COPY_V2NV, 2'b11);
			if (k == 1)
				m.start();
			m.stop();
			if (k == 0)
				exp_nv = {cfg, lo, hi};
			repeat (20) @(posedge clk);
			chk(busy, k == 0);
			if (k == 0) begin
				xfer(`ARA_BYTE, 8'hFF, 2'b00);
				m.stop();
				@(posedge clk) #1 cfg = ~cfg;
				xfer({`DEV_ADDR_HI, pins, 1'b0}, `CMD_COPY_V2NV, 2'b11);
				m.stop();
				// the copy captures config_i when busy ends, so put them back
				@(posedge clk) #1 cfg = exp_nv[47:32];
			end
			for (int i = 0; i < 2000 && busy !== 1'b0; i++)
				@(posedge clk);
			repeat (4) @(posedge clk);
			chk({nv_c, nv_l, nv_h}, exp_nv);
		end
		@(posedge clk) #1 {lk, lkd} = 2'b00;
		m.start();
		m.wr_byte(`ARA_BYTE, ack);
		chk(ack, 1'b1);
		m.rd_byte(8'h90, rb);
		m.stop();
		chk(alert_n, 1'b0);
		m.start();
		m.wr_byte(`ARA_BYTE, ack);
		m.bit_io(1'b1, ack);
		#100 chk(oe_n, 1'b0);
		#1250 chk(oe_n, 1'b1);
		m.stop();
		for (int e = 1; e >= 0; e--) begin
			if (e == 0)
				ev(1'b0);
			m.start();
			m.wr_byte(`ARA_BYTE, ack);
			chk(ack, 1'b1);
			m.rd_byte(8'hFF, rb);
			m.stop();
			chk(rb, reply(pins, e[0]));
			chk(alert_n, 1'b1);
		end
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) #1 {tis, alert_polarity} = {k == 2, k != 0};
			ev(1'b1);
			chk(alert_n, 1'b1);
			xfer(`ARA_BYTE, 8'hFF, 2'b00);
			m.stop();
		end
		@(posedge clk) #1 pins = ~pins;
		xfer(`GC_BYTE, `GC_RELATCH, 2'b11);
		m.stop();
		chk(addr_q, pins);
		xfer(8'h01, `GC_RELATCH, 2'b00);
		m.stop();
		@(posedge clk) #1 pins = pins + 3'h1;
		xfer(`GC_BYTE, `GC_RESET, 2'b11);
		m.stop();
		repeat (40) @(posedge clk);
		chk({addr_q, busy}, {pins, 1'b0});
		chk(reloads, 1);
		chk(ptr_w, 0);
		rb = 8'($urandom) & 8'hBF;
		xfer({`DEV_ADDR_HI, pins, 1'b0}, rb, 2'b11);
		m.stop();
		xfer({`DEV_ADDR_HI, pins, 1'b0}, `CMD_COPY_V2NV, 2'b11);
		m.stop();
		xfer({`DEV_ADDR_HI, pins, 1'b1}, 8'hFF, 2'b00);
		m.stop();
		xfer(`GC_BYTE, `GC_RELATCH, 2'b00);
		m.stop();
		chk({ptr_w, ptr}, {32'h1, rb});
		chk(busy, 1'b1);
		for (int i = 0; i < 2000 && busy !== 1'b0; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		chk({nv_c, nv_l, nv_h}, {cfg, lo, hi});
		xfer({`DEV_ADDR_HI, pins - 3'h1, 1'b0}, `CMD_COPY_V2NV, 2'b00);
		m.stop();
		test_done();
	end
endmodule
